//--- logic/output_divider_consts.svh
// Register offsets, field positions, reset values and timing for the output divider control
`ifndef OUTPUT_DIVIDER_CONSTS_SVH
`define OUTPUT_DIVIDER_CONSTS_SVH

`define ADDR_VCO_POST_DIVIDER_LOW        8'h0A
`define ADDR_DIVIDER_SELECT_HIGH         8'h0B
`define ADDR_DISABLED_OUTPUT_LEVEL_CTRL  8'h0E
`define ADDR_GLOBAL_RESET_CTRL           8'h80
`define ADDR_OUTPUT_AND_CALIBRATION_CTRL 8'h84

`define RST_VCO_POST_DIVIDER  10'h00A
`define RST_FINAL_DIVIDER     3'h0
`define RST_DISABLED_LEVEL    2'h0
`define RST_OUTPUT_ENABLE     1'h1
`define RST_RESERVED_BYTE     8'h00

`define BIT_GLOBAL_RESET      7
`define BIT_OUTPUT_ENABLE     2
`define BIT_CALIBRATE         0
`define FLD_FINAL_DIV_HI      6
`define FLD_FINAL_DIV_LO      4
`define FLD_LEVEL_HI          5
`define FLD_LEVEL_LO          4

`define DIV_MIN               10'h00A
`define DIV_MAX               10'h3FE
`define FINAL_CODE_MAX        3'h5

`define LEVEL_HIGH_Z          2'h0
`define LEVEL_DRIVE_HIGH      2'h1
`define LEVEL_DRIVE_LOW       2'h2

`define CLOCK_PERIOD_NS       100
`define CAL_MAX_TIME_MS       10
`define CAL_MAX_CYCLES        ((`CAL_MAX_TIME_MS * 1000000) / `CLOCK_PERIOD_NS)
`define CAL_DEFAULT_CYCLES    (`CAL_MAX_CYCLES / 2)

`endif

//--- logic/output_divider_pkg.sv
// Types shared by the output divider control design
package output_divider_pkg;
  typedef enum logic [1:0] {
    CAL_IDLE = 2'b01,
    CAL_BUSY = 2'b10
  } cal_state_t;
  typedef logic [7:0] byte_t;
  typedef logic [9:0] div_t;
endpackage

//--- logic/output_post_divider.sv
// Divide-by-N then divide-by-2^k counter chain for the output clock
`timescale 1ns/1ns
`include "output_divider_consts.svh"
module output_post_divider #(
  parameter int DIV_W = 10
) (
  // Clock and reset
  input  wire logic             clock_in,
  input  wire logic             rst_b_in,
  // Settings
  input  wire logic [DIV_W-1:0] vco_post_divider_in,
  input  wire logic [2:0]       final_output_divider_in,
  // Clock out
  output logic                  clock_out
);
  logic [DIV_W-1:0] hs_count;
  logic             hs_clock;
  logic [4:0]       ls_count;
  logic             hs_rise;
  logic             ls_tap;
  logic             ls_prev;

  // Half-period count; every ratio gives 50% duty, odd ratios run one cycle short
  always_ff @(posedge clock_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      hs_count <= '0;
      hs_clock <= 1'b0;
    end else if (hs_count >= (vco_post_divider_in >> 1) - DIV_W'(1)) begin
      hs_count <= '0;
      hs_clock <= ~hs_clock;
    end else begin
      hs_count <= hs_count + DIV_W'(1);
    end
  end

  assign hs_rise = (hs_count == '0) && hs_clock;

  always_ff @(posedge clock_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      ls_count <= '0;
    end else if (hs_rise) begin
      ls_count <= ls_count + 5'h01;
    end
  end

  always_comb begin
    case (final_output_divider_in)
      3'h0:    ls_tap = hs_clock;
      3'h1:    ls_tap = ls_count[0];
      3'h2:    ls_tap = ls_count[1];
      3'h3:    ls_tap = ls_count[2];
      3'h4:    ls_tap = ls_count[3];
      3'h5:    ls_tap = ls_count[4];
      default: ls_tap = hs_clock;
    endcase
  end

  always_ff @(posedge clock_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      ls_prev <= 1'b0;
    end else begin
      ls_prev <= ls_tap;
    end
  end

  assign clock_out = ls_prev;
endmodule

//--- logic/calibration_timer.sv
// Bounded-length frequency calibration sequencer
`timescale 1ns/1ns
`include "output_divider_consts.svh"
module calibration_timer #(
  parameter int CAL_CYCLES = `CAL_DEFAULT_CYCLES
) (
  // Clock and reset
  input  wire logic clock_in,
  input  wire logic rst_b_in,
  input  wire logic soft_reset_in,
  // Control
  input  wire logic start_in,
  output logic      busy_out,
  output logic      done_out
);
  import output_divider_pkg::*;
  cal_state_t  state;
  logic [31:0] count;

  always_ff @(posedge clock_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      state    <= CAL_IDLE;
      count    <= 32'h0;
      done_out <= 1'b0;
    end else if (soft_reset_in) begin
      state    <= CAL_IDLE;
      count    <= 32'h0;
      done_out <= 1'b0;
    end else begin
      done_out <= 1'b0;
      case (state)
        CAL_IDLE: begin
          if (start_in) begin
            state <= CAL_BUSY;
            count <= 32'h0;
          end
        end
        CAL_BUSY: begin
          if (count >= 32'(CAL_CYCLES - 1)) begin
            state    <= CAL_IDLE;
            done_out <= 1'b1;
          end else begin
            count <= count + 32'h1;
          end
        end
        default: state <= CAL_IDLE;
      endcase
    end
  end

  assign busy_out = (state == CAL_BUSY);
endmodule

//--- logic/output_divider_enable_control.sv
// Register file and output path control for the programmable oscillator
// Functional notes
// - High-speed divider ratio is even, 10 to 1022, binary value is ratio.
// - Divider bits 7:0 in low register, bits 9:8 in bits 1:0 next.
// - Last-stage field bits 6:4 divides by 1..32 for codes 0..5.
// - Last-stage divider writes act on the divider at once.
// - Disabled-level bits 5:4: 00 high-Z, 10 low, 01 high, 11 reserved.
// - Global reset bit 7 restores every register default, then clears itself.
// - Output enable bit 2 set drives the clock through an active driver.
// - Output enable clear powers driver down; output takes disabled level.
// - Writing 1 to calibrate bit 0 starts calibration; bit self-clears.
// - Calibration finishes within 10 ms of starting.
`timescale 1ns/1ns
`include "output_divider_consts.svh"
module output_divider_enable_control #(
  parameter int CAL_CYCLES = `CAL_DEFAULT_CYCLES
) (
  // Clock and reset
  input  wire logic                     clock_in,
  input  wire logic                     rst_b_in,
  // Register port from the serial bus engine
  input  wire logic                     reg_write_in,
  input  wire logic                     reg_read_in,
  input  wire output_divider_pkg::byte_t reg_addr_in,
  input  wire output_divider_pkg::byte_t reg_wdata_in,
  output output_divider_pkg::byte_t     reg_rdata_out,
  // Clock output pin
  output logic                          clk_pin_out,
  output logic                          clk_pin_oe_b_out,
  output logic                          driver_powered_out,
  // Status
  output logic                          calibrating_out,
  output logic                          divider_setting_valid_out
);
  import output_divider_pkg::*;

  // Programmed fields
  div_t       vco_post_divider;
  logic [2:0] final_output_divider;
  logic [1:0] disabled_level;
  logic       output_enable;
  logic       freq_calibrate_trigger;

  // Reserved bits, kept so a read-modify-write host sees what it wrote
  byte_t      resv_level;
  logic [1:0] resv_div_high;
  logic       resv_div_high7;
  byte_t      resv_out_ctrl;

  // Internal strobes and status
  logic       soft_reset;
  logic       cal_start;
  logic       cal_busy;
  logic       cal_done;
  logic       divided_clock;
  logic       wr_div_low;
  logic       wr_div_high;
  logic       wr_level;
  logic       wr_ctrl;
  logic       wr_reset;

  // Next values
  div_t       next_vco_post_divider;
  byte_t      next_rdata;
  logic       next_pin;
  logic       next_pin_oe_b;

  // Address compare shared by the write-strobe decoders
  function automatic logic hit(input byte_t a, input byte_t target);
    return a == target;
  endfunction

  function automatic logic div_ok(input div_t d, input logic [2:0] f);
    return !d[0] && d >= `DIV_MIN && d <= `DIV_MAX && f <= `FINAL_CODE_MAX;
  endfunction

  function automatic logic parked_pin(input logic [1:0] level);
    case (level)
      `LEVEL_DRIVE_HIGH: return 1'b1;
      default:           return 1'b0;
    endcase
  endfunction

  function automatic logic parked_oe_b(input logic [1:0] level);
    case (level)
      `LEVEL_DRIVE_LOW:  return 1'b0;
      `LEVEL_DRIVE_HIGH: return 1'b0;
      default:           return 1'b1;
    endcase
  endfunction

  // Write strobes, one per register
  assign wr_div_low  = reg_write_in && hit(reg_addr_in, `ADDR_VCO_POST_DIVIDER_LOW);
  assign wr_div_high = reg_write_in && hit(reg_addr_in, `ADDR_DIVIDER_SELECT_HIGH);
  assign wr_level    = reg_write_in && hit(reg_addr_in, `ADDR_DISABLED_OUTPUT_LEVEL_CTRL);
  assign wr_ctrl     = reg_write_in && hit(reg_addr_in, `ADDR_OUTPUT_AND_CALIBRATION_CTRL);
  assign wr_reset    = reg_write_in && hit(reg_addr_in, `ADDR_GLOBAL_RESET_CTRL);

  assign soft_reset = wr_reset && reg_wdata_in[`BIT_GLOBAL_RESET];

  always_comb begin
    next_vco_post_divider = vco_post_divider;
    if (wr_div_low) begin
      next_vco_post_divider[7:0] = reg_wdata_in;
    end
    if (wr_div_high) begin
      next_vco_post_divider[9:8] = reg_wdata_in[1:0];
    end
  end

  // ratio register; legality is reported, not enforced
  always_ff @(posedge clock_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      vco_post_divider <= `RST_VCO_POST_DIVIDER;
    end else if (soft_reset) begin
      vco_post_divider <= `RST_VCO_POST_DIVIDER;
    end else begin
      vco_post_divider <= next_vco_post_divider;
    end
  end

  // last-stage field and reserved bits of the select register
  always_ff @(posedge clock_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      final_output_divider <= `RST_FINAL_DIVIDER;
      resv_div_high        <= 2'h0;
      resv_div_high7       <= 1'b0;
    end else if (soft_reset) begin
      final_output_divider <= `RST_FINAL_DIVIDER;
      resv_div_high        <= 2'h0;
      resv_div_high7       <= 1'b0;
    end else if (wr_div_high) begin
      final_output_divider <= reg_wdata_in[`FLD_FINAL_DIV_HI:`FLD_FINAL_DIV_LO];
      resv_div_high        <= reg_wdata_in[3:2];
      resv_div_high7       <= reg_wdata_in[7];
    end
  end

  always_ff @(posedge clock_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      disabled_level <= `RST_DISABLED_LEVEL;
    end else if (soft_reset) begin
      disabled_level <= `RST_DISABLED_LEVEL;
    end else if (wr_level) begin
      disabled_level <= reg_wdata_in[`FLD_LEVEL_HI:`FLD_LEVEL_LO];
    end
  end

  // Reserved bits of the level register; field bits held at zero here
  always_ff @(posedge clock_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      resv_level <= `RST_RESERVED_BYTE;
    end else if (soft_reset) begin
      resv_level <= `RST_RESERVED_BYTE;
    end else if (wr_level) begin
      resv_level <= {reg_wdata_in[7:6], 2'h0, reg_wdata_in[3:0]};
    end
  end

  always_ff @(posedge clock_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      output_enable <= `RST_OUTPUT_ENABLE;
    end else if (soft_reset) begin
      output_enable <= `RST_OUTPUT_ENABLE;
    // a cleared bit powers the driver down
    end else if (wr_ctrl) begin
      output_enable <= reg_wdata_in[`BIT_OUTPUT_ENABLE];
    end
  end

  // Reserved bits of the control register; enable and trigger held elsewhere
  always_ff @(posedge clock_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      resv_out_ctrl <= `RST_RESERVED_BYTE;
    end else if (soft_reset) begin
      resv_out_ctrl <= `RST_RESERVED_BYTE;
    end else if (wr_ctrl) begin
      resv_out_ctrl <= {reg_wdata_in[7:3], 1'b0, reg_wdata_in[1], 1'b0};
    end
  end

  // start on a written one; a running cycle is not restarted
  assign cal_start = wr_ctrl && reg_wdata_in[`BIT_CALIBRATE] && !cal_busy;

  // Trigger bit stands while calibrating; a zero write cannot abort
  always_ff @(posedge clock_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      freq_calibrate_trigger <= 1'b0;
    end else if (soft_reset) begin
      freq_calibrate_trigger <= 1'b0;
    // a new start wins over a same-cycle completion
    end else if (cal_start) begin
      freq_calibrate_trigger <= 1'b1;
    end else if (cal_done) begin
      freq_calibrate_trigger <= 1'b0;
    end
  end

  // calibration sequencer; soft reset aborts a run in progress
  calibration_timer #(
    .CAL_CYCLES(CAL_CYCLES)
  ) u_cal (
    .clock_in      (clock_in),
    .rst_b_in      (rst_b_in),
    .soft_reset_in (soft_reset),
    .start_in      (cal_start),
    .busy_out      (cal_busy),
    .done_out      (cal_done)
  );

  // Counter chain takes the ratio live, so the host must follow the change sequence
  output_post_divider #(
    .DIV_W(10)
  ) u_div (
    .clock_in                (clock_in),
    .rst_b_in                (rst_b_in),
    .vco_post_divider_in     (vco_post_divider),
    .final_output_divider_in (final_output_divider),
    .clock_out               (divided_clock)
  );

  // Read value of the addressed register; unmapped addresses read zero
  always_comb begin
    next_rdata = 8'h00;
    case (reg_addr_in)
      `ADDR_VCO_POST_DIVIDER_LOW: begin
        next_rdata = vco_post_divider[7:0];
      end
      // upper ratio bits beside the last-stage field
      `ADDR_DIVIDER_SELECT_HIGH: begin
        next_rdata = {resv_div_high7, final_output_divider, resv_div_high,
                      vco_post_divider[9:8]};
      end
      `ADDR_DISABLED_OUTPUT_LEVEL_CTRL: begin
        next_rdata = resv_level | {2'h0, disabled_level, 4'h0};
      end
      // reset bit self-clears, so it always reads zero
      `ADDR_GLOBAL_RESET_CTRL: begin
        next_rdata = 8'h00;
      end
      // trigger bit readable for completion polling
      `ADDR_OUTPUT_AND_CALIBRATION_CTRL: begin
        next_rdata = resv_out_ctrl | {5'h00, output_enable, 1'b0, freq_calibrate_trigger};
      end
      default: begin
        next_rdata = 8'h00;
      end
    endcase
  end

  // Read data holds until the next read strobe
  always_ff @(posedge clock_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      reg_rdata_out <= 8'h00;
    end else if (reg_read_in) begin
      reg_rdata_out <= next_rdata;
    end
  end

  always_comb begin
    next_pin      = divided_clock;
    next_pin_oe_b = 1'b0;
    if (!output_enable) begin
      next_pin      = parked_pin(disabled_level);
      next_pin_oe_b = parked_oe_b(disabled_level);
    end
  end

  // Registered pin drive, so enable changes never glitch the pin
  always_ff @(posedge clock_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      clk_pin_out      <= 1'b0;
      clk_pin_oe_b_out <= 1'b1;
    end else begin
      clk_pin_out      <= next_pin;
      clk_pin_oe_b_out <= next_pin_oe_b;
    end
  end

  assign driver_powered_out        = output_enable;
  assign calibrating_out           = cal_busy;
  assign divider_setting_valid_out = div_ok(vco_post_divider, final_output_divider);
endmodule

//--- dv/output_divider_enable_control_properties.sv
// Port-level properties of the output divider control
`timescale 1ns/1ns
module output_divider_enable_control_properties #(
  parameter int CAL_CYCLES = 20
) (
  // Watched ports
  input wire logic                      clock_in,
  input wire logic                      rst_b_in,
  input wire logic                      reg_write_in,
  input wire logic                      reg_read_in,
  input wire output_divider_pkg::byte_t reg_addr_in,
  input wire output_divider_pkg::byte_t reg_wdata_in,
  input wire output_divider_pkg::byte_t reg_rdata_out,
  input wire logic                      clk_pin_out,
  input wire logic                      clk_pin_oe_b_out,
  input wire logic                      driver_powered_out,
  input wire logic                      calibrating_out,
  input wire logic                      divider_setting_valid_out
);
  import output_divider_pkg::*;
  int   cal_len;
  logic wr84;
  default clocking @(posedge clock_in); endclocking
  default disable iff (!rst_b_in);
  assign wr84 = reg_write_in && reg_addr_in == 8'h84;
  always_ff @(posedge clock_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      cal_len <= 0;
    end else begin
      cal_len <= calibrating_out ? cal_len + 1 : 0;
    end
  end
  property p_div_odd;
    reg_write_in && reg_addr_in == 8'h0A && reg_wdata_in[0] |=> !divider_setting_valid_out;
  endproperty
  a_div_odd: assert property (p_div_odd) else $error("odd divider valid");
  property p_fin_rsv;
    reg_write_in && reg_addr_in == 8'h0B && reg_wdata_in[6:4] > 3'h5
      |=> !divider_setting_valid_out;
  endproperty
  a_fin_rsv: assert property (p_fin_rsv) else $error("reserved code valid");
  property p_en_wr;
    wr84 |=> driver_powered_out == $past(reg_wdata_in[2]);
  endproperty
  a_en_wr: assert property (p_en_wr) else $error("enable not stored");
  property p_oe_on;
    $past(rst_b_in, 2) && $past(driver_powered_out, 2) && $past(driver_powered_out)
      |-> !clk_pin_oe_b_out;
  endproperty
  a_oe_on: assert property (p_oe_on) else $error("enabled pin not driven");
  property p_soft;
    reg_write_in && reg_addr_in == 8'h80 && reg_wdata_in[7]
      |-> ##[1:2] driver_powered_out && divider_setting_valid_out && !calibrating_out;
  endproperty
  a_soft: assert property (p_soft) else $error("soft reset missed");
  property p_cal_go;
    wr84 && reg_wdata_in[0] && !calibrating_out |=> calibrating_out;
  endproperty
  a_cal_go: assert property (p_cal_go) else $error("calibration not started");
  property p_cal_len;
    cal_len <= CAL_CYCLES + 2;
  endproperty
  a_cal_len: assert property (p_cal_len) else $error("calibration too long");
  property p_cal_poll;
    reg_read_in && reg_addr_in == 8'h84 && calibrating_out ##1 calibrating_out
      |-> reg_rdata_out[0];
  endproperty
  a_cal_poll: assert property (p_cal_poll) else $error("trigger bit early clear");
  c_cal: cover property ($rose(calibrating_out));
  c_off: cover property ($fell(driver_powered_out));
  c_soft: cover property (reg_write_in && reg_addr_in == 8'h80 && reg_wdata_in[7]);
endmodule
bind output_divider_enable_control output_divider_enable_control_properties #(
  .CAL_CYCLES(CAL_CYCLES)
) props_i (
  .clock_in(clock_in), .rst_b_in(rst_b_in), .reg_write_in(reg_write_in),
  .reg_read_in(reg_read_in), .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in),
  .reg_rdata_out(reg_rdata_out), .clk_pin_out(clk_pin_out),
  .clk_pin_oe_b_out(clk_pin_oe_b_out), .driver_powered_out(driver_powered_out),
  .calibrating_out(calibrating_out), .divider_setting_valid_out(divider_setting_valid_out)
);

//--- dv/reg_host_model.sv
// Host that programs the oscillator registers
`timescale 1ns/1ns
module reg_host_model (
  // Clock
  input  wire logic                      clock_in,
  // Register port
  output logic                           reg_write_out,
  output logic                           reg_read_out,
  output output_divider_pkg::byte_t      reg_addr_out,
  output output_divider_pkg::byte_t      reg_wdata_out,
  input  wire output_divider_pkg::byte_t reg_rdata_in
);
  import output_divider_pkg::*;
  initial begin
    reg_write_out = 1'b0;
    reg_read_out = 1'b0;
    reg_addr_out = 8'h00;
    reg_wdata_out = 8'h00;
  end
  // Idle bus shows the inverse, never the last value
  task automatic wr(input byte_t a, input byte_t d);
    @(negedge clock_in);
    reg_write_out = 1'b1;
    reg_addr_out = a;
    reg_wdata_out = d;
    @(negedge clock_in);
    reg_write_out = 1'b0;
    reg_addr_out = ~a;
    reg_wdata_out = ~d;
  endtask
  task automatic rd(input byte_t a, output byte_t d);
    @(negedge clock_in);
    reg_read_out = 1'b1;
    reg_addr_out = a;
    @(negedge clock_in);
    reg_read_out = 1'b0;
    reg_addr_out = ~a;
    d = reg_rdata_in;
  endtask
  task automatic lfc(input div_t dv, input logic [2:0] code, output int polls);
    byte_t v;
    byte_t oc;
    rd(8'h84, oc);
    wr(8'h84, oc & 8'hFA);
    // dividers inside the sequence, reserved kept
    wr(8'h0A, dv[7:0]);
    rd(8'h0B, v);
    wr(8'h0B, {v[7], code, v[3:2], dv[9:8]});
    wr(8'h84, (oc & 8'hFA) | 8'h01);
    polls = 0;
    do begin
      rd(8'h84, v);
      polls++;
    end while (v[0] && polls < 500);
    wr(8'h84, v | 8'h04);
  endtask
endmodule

//--- dv/output_divider_enable_control_tb.sv
// Self-checking bench for the output divider control
`timescale 1ns/1ns
module output_divider_enable_control_tb;
  import output_divider_pkg::*;
  localparam int CAL = 20;
  logic  clock_in, rst_b_in, reg_write_in, reg_read_in;
  byte_t reg_addr_in, reg_wdata_in, reg_rdata_out, v, d, a;
  logic  clk_pin_out, clk_pin_oe_b_out, driver_powered_out, calibrating_out, valid;
  int    num_errors, n_checks, cycles, n, t0, i;
  div_t  dv;
  logic [2:0] cd;
  byte_t adr[6] = '{8'h0A, 8'h0B, 8'h0E, 8'h80, 8'h84, 8'h0C};
  byte_t dfl[6] = '{8'h0A, 8'h00, 8'h00, 8'h00, 8'h04, 8'h00};
  output_divider_enable_control #(.CAL_CYCLES(CAL)) output_divider_enable_control_i (
    .clock_in(clock_in), .rst_b_in(rst_b_in), .reg_write_in(reg_write_in),
    .reg_read_in(reg_read_in), .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in),
    .reg_rdata_out(reg_rdata_out), .clk_pin_out(clk_pin_out),
    .clk_pin_oe_b_out(clk_pin_oe_b_out), .driver_powered_out(driver_powered_out),
    .calibrating_out(calibrating_out), .divider_setting_valid_out(valid));
  reg_host_model reg_host_model_i (
    .clock_in(clock_in), .reg_write_out(reg_write_in), .reg_read_out(reg_read_in),
    .reg_addr_out(reg_addr_in), .reg_wdata_out(reg_wdata_in), .reg_rdata_in(reg_rdata_out));
  function automatic logic ok(div_t x, logic [2:0] c);
    return !x[0] && x >= 10'd10 && x <= 10'd1022 && c <= 3'h5;
  endfunction
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    n_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic conclude();
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic defaults();
    for (int k = 0; k < 6; k++) begin
      reg_host_model_i.rd(adr[k], v);
      chk("default", dfl[k], v);
    end
  endtask
  initial begin
    clock_in = 1'b0;
    forever #50 clock_in = ~clock_in;
  end
  // Cycle ceiling cuts a hang short
  always @(posedge clock_in) begin
    cycles++;
    if (cycles == 30000) begin
      num_errors++;
      conclude();
    end
  end
  initial begin
    rst_b_in = 1'b0;
    void'($urandom(32'hFCB5D91A));
    repeat (6) @(negedge clock_in);
    rst_b_in = 1'b1;
    defaults();
    $display("reset defaults done");
    dv = 10'd10;
    cd = 3'h0;
    for (i = 0; i < 15; i++) begin
      a = adr[i % 3];
      d = $urandom;
      reg_host_model_i.wr(a, d);
      reg_host_model_i.rd(a, v);
      chk("readback", d, v);
      if (a == 8'h0A) dv[7:0] = d;
      if (a == 8'h0B) {cd, dv[9:8]} = {d[6:4], d[1:0]};
      chk("valid", ok(dv, cd), valid);
    end
    $display("readback done");
    for (i = 0; i < 8; i++) begin
      dv = (i == 7) ? 10'd10 + 10'($urandom % 500) * 2 : 10'd10 + 10'(i % 3) * 6;
      cd = (i == 7) ? 3'h0 : 3'(i % 6);
      reg_host_model_i.lfc(dv, cd, n);
      chk("valid", 1'b1, valid);
      @(posedge clk_pin_out);
      @(posedge clk_pin_out);
      t0 = cycles;
      @(posedge clk_pin_out);
      chk("period", dv << cd, 16'(cycles - t0));
    end
    reg_host_model_i.wr(8'h0B, 8'h60);
    chk("valid", 1'b0, valid);
    $display("divider done");
    for (i = 0; i < 4; i++) begin
      reg_host_model_i.wr(8'h0E, 8'(i << 4));
      reg_host_model_i.wr(8'h84, 8'h00);
      repeat (3) @(negedge clock_in);
      chk("powered", 1'b0, driver_powered_out);
      chk("oe_b", (i == 1 || i == 2) ? 1'b0 : 1'b1, clk_pin_oe_b_out);
      if (i == 1 || i == 2) chk("level", i == 1, clk_pin_out);
      reg_host_model_i.wr(8'h84, 8'h04);
      repeat (3) @(negedge clock_in);
      chk("oe_b on", 1'b0, clk_pin_oe_b_out);
    end
    $display("disabled level done");
    reg_host_model_i.wr(8'h84, 8'h05);
    chk("calibrating", 1'b1, calibrating_out);
    reg_host_model_i.wr(8'h84, 8'h04);
    for (n = 0; n < 200 && calibrating_out; n++) @(negedge clock_in);
    chk("cal length ok", 1'b1, n <= CAL + 2);
    reg_host_model_i.rd(8'h84, v);
    chk("trigger", 8'h04, v);
    $display("calibration done");
    reg_host_model_i.wr(8'h0E, 8'h30);
    reg_host_model_i.wr(8'h0B, 8'h55);
    reg_host_model_i.wr(8'h84, 8'h00);
    reg_host_model_i.wr(8'h80, 8'h80);
    defaults();
    $display("soft reset done");
    conclude();
  end
endmodule
